// ==== qdac_defines.vh ====
// Purpose: constants for the quad converter two-wire host controller
// Assumes: 250 MHz mclk, byte-addressed AXI4-Lite register window
// Notes:   definitions only
`ifndef QDAC_DEFINES_VH
`define QDAC_DEFINES_VH

// register window
`define QDAC_AW          4
`define QDAC_REG_CMD     4'h0
`define QDAC_REG_STAT    4'h4
`define QDAC_RESP_OKAY   2'b00
`define QDAC_RESP_SLVERR 2'b10

// command register fields
`define QDAC_F_NIB_HI    15
`define QDAC_F_NIB_LO    12
`define QDAC_F_CODE_HI   11
`define QDAC_F_CODE_LO   2
`define QDAC_F_SEL_HI    19
`define QDAC_F_SEL_LO    16
`define QDAC_F_SD_HI     21
`define QDAC_F_SD_LO     20
`define QDAC_F_LSB       24
`define QDAC_F_GO        31
`define QDAC_CMD_MASK    32'h013FFFFC

// status register fields
`define QDAC_F_BUSY      16
`define QDAC_F_NACK      17
`define QDAC_F_DONE      18

// shutdown selector codes
`define QDAC_SD_UP       2'b00
`define QDAC_SD_FLOAT    2'b01
`define QDAC_SD_R1K      2'b10
`define QDAC_SD_R100K    2'b11

// command nibbles of interest to the sequencer
`define QDAC_NIB_UPDATE  4'hE
`define QDAC_NIB_EXT     4'hF
`define QDAC_CODE_TOP0   4'h0

// link timing
`define QDAC_MCLK_NS     4
`define QDAC_SCL_NS      2500
`define QDAC_QTR_W       10

// byte sequence slots
`define QDAC_IDX_ADDR_W  3'd0
`define QDAC_IDX_ADDR_R  3'd4
`define QDAC_IDX_RD_HI   3'd5
`define QDAC_IDX_RD_LO   3'd6
`define QDAC_ACK_BIT     4'd8

`endif

// ==== qdac_sync.v ====
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to mclk
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module qdac_sync #(
  parameter W = 2
) (
  // clock and reset
  input  wire         mclk,
  input  wire         reset,
  // pins in, synchronised out
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta;

  // reset to released-bus level, lines idle high
  always @(posedge mclk) begin
    if (reset) begin
      meta <= {W{1'b1}};
      dout <= {W{1'b1}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ==== qdac_axil.v ====
// Purpose: AXI4-Lite slave holding the command register and reading back the status input
// Assumes: one outstanding write and one outstanding read
// Notes:   unmapped writes answer SLVERR, unmapped reads read zero
`timescale 1ns/1ps
`include "qdac_defines.vh"
module qdac_axil (
  // clock and reset
  input  wire               mclk,
  input  wire               reset,
  // write channels
  input  wire [`QDAC_AW-1:0] awaddr,
  input  wire               awvalid,
  output reg                awready,
  input  wire [31:0]        wdata,
  input  wire [3:0]         wstrb,
  input  wire               wvalid,
  output reg                wready,
  output reg  [1:0]         bresp,
  output reg                bvalid,
  input  wire               bready,
  // read channels
  input  wire [`QDAC_AW-1:0] araddr,
  input  wire               arvalid,
  output reg                arready,
  output reg  [31:0]        rdata,
  output reg  [1:0]         rresp,
  output reg                rvalid,
  input  wire               rready,
  // controller side
  output reg  [31:0]        cmd,
  output reg                go,
  input  wire [31:0]        status
);
  integer i;
  wire wr_fire = awvalid && wvalid && awready && wready;
  wire wr_cmd  = (awaddr == `QDAC_REG_CMD);
  wire [31:0] cmd_mask = `QDAC_CMD_MASK;

  always @(posedge mclk) begin
    if (reset) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `QDAC_RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rresp   <= `QDAC_RESP_OKAY;
      rdata   <= 32'h00000000;
      // wake-up selector as default, software still must send it
      cmd     <= {10'h000, `QDAC_SD_UP, 20'h00000};
      go      <= 1'b0;
    end else begin
      // both channels are waited for, so arrival order does not matter
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready  <= awvalid && wvalid && !wready && !bvalid;
      go      <= 1'b0;
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= wr_cmd ? `QDAC_RESP_OKAY : `QDAC_RESP_SLVERR;
        if (wr_cmd) begin
          for (i = 0; i < 4; i = i + 1) begin
            if (wstrb[i]) begin
              cmd[i*8 +: 8] <= wdata[i*8 +: 8] & cmd_mask[i*8 +: 8];
            end
          end
          go <= wstrb[3] && wdata[`QDAC_F_GO];
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= `QDAC_RESP_OKAY;
        case (araddr)
          `QDAC_REG_CMD: begin
            rdata <= cmd | {status[`QDAC_F_BUSY], 31'h00000000};
          end
          `QDAC_REG_STAT: begin
            rdata <= status;
          end
          default: begin
            rdata <= 32'h00000000;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

// ==== qdac_host.v ====
// Purpose: two-wire bus master that drives a quad 10-bit converter slave
// Assumes: 250 MHz mclk, open-drain lines with external pull-ups
// Notes:   software fills the command register and sets go; the
//          sequence is chosen from the command nibble
// Function
// - each byte is eight data bits plus one acknowledge clock
// - data changes only while clock low; both lines idle high
// - start is data falling with clock high, stop data rising
// - at least one clock pulse between any start and stop
// - writes may run back to back; reads need a repeated start
// - receiver pulls data low on the ninth clock to acknowledge
// - missing acknowledge marks the transfer failed for retry
// - address byte lsb zero writes, one reads
// - write carries nibble, 10-bit code and two zero sub-bits
// - nibble 1110 updates outputs; the low byte is not sent
// - nibble 1111 with one-hot top bits selects a channel read
`timescale 1ns/1ps
`include "qdac_defines.vh"
module qdac_host #(
  parameter [5:0] ADDR_HI  = 6'h2A, // arbitrary fixed address bits
  parameter       SCL_NS   = `QDAC_SCL_NS,
  parameter       MCLK_NS  = `QDAC_MCLK_NS
) (
  // clock and reset
  input  wire                mclk,
  input  wire                reset,
  // AXI4-Lite write
  input  wire [`QDAC_AW-1:0] awaddr,
  input  wire                awvalid,
  output wire                awready,
  input  wire [31:0]         wdata,
  input  wire [3:0]          wstrb,
  input  wire                wvalid,
  output wire                wready,
  output wire [1:0]          bresp,
  output wire                bvalid,
  input  wire                bready,
  // AXI4-Lite read
  input  wire [`QDAC_AW-1:0] araddr,
  input  wire                arvalid,
  output wire                arready,
  output wire [31:0]         rdata,
  output wire [1:0]          rresp,
  output wire                rvalid,
  input  wire                rready,
  // serial clock line
  input  wire                scl_i,
  output reg                 scl_o,
  output reg                 scl_oe_n,
  // serial data line
  input  wire                sda_i,
  output reg                 sda_o,
  output reg                 sda_oe_n
);
  // quarter bit period, least time rounded up
  localparam integer QTR = (SCL_NS + 4*MCLK_NS - 1) / (4*MCLK_NS);
  localparam [`QDAC_QTR_W-1:0] QTR_LAST = QTR[`QDAC_QTR_W-1:0] - 1'b1;

  // one-hot sequencer states
  localparam [3:0] S_IDLE  = 4'b0001;
  localparam [3:0] S_START = 4'b0010;
  localparam [3:0] S_BIT   = 4'b0100;
  localparam [3:0] S_STOP  = 4'b1000;

  wire [31:0] cmd;
  wire        go;
  wire [1:0]  line_s;
  wire        scl_s = line_s[1];
  wire        sda_s = line_s[0];

  reg  [3:0]  state;
  reg  [1:0]  phase;
  reg  [3:0]  bitn;
  reg  [2:0]  idx;
  reg  [2:0]  nw;
  reg         is_rd;
  reg  [7:0]  shreg;
  reg  [7:0]  hi_b;
  reg  [7:0]  lo_b;
  reg  [7:0]  ext_b;
  reg         lsb;
  reg  [15:0] rback;
  reg         busy;
  reg         nack;
  reg         done;
  reg  [`QDAC_QTR_W-1:0] qcnt;
  reg         tick;

  wire [31:0] status = {13'h0000, done, nack, busy, rback};
  // slots in which the slave drives the data line
  wire        rx_byte = (idx == `QDAC_IDX_RD_HI) || (idx == `QDAC_IDX_RD_LO);

  // byte sent in each slot of the sequence
  function [7:0] byte_at;
    input [2:0] slot;
    input       slsb;
    input [7:0] h;
    input [7:0] l;
    input [7:0] e;
    begin
      case (slot)
        3'd0:    byte_at = {ADDR_HI, slsb, 1'b0};
        3'd1:    byte_at = h;
        3'd2:    byte_at = l;
        3'd3:    byte_at = e;
        3'd4:    byte_at = {ADDR_HI, slsb, 1'b1};
        default: byte_at = 8'hFF;
      endcase
    end
  endfunction

  // ones in all positions keep the data line released while receiving
  wire [7:0] next_byte = byte_at(idx + 3'd1, lsb, hi_b, lo_b, ext_b);

  qdac_axil u_regs (
    .mclk    (mclk),
    .reset   (reset),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .cmd     (cmd),
    .go      (go),
    .status  (status)
  );

  // both lines pass two flops before any logic reads them
  qdac_sync #(.W(2)) u_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   ({scl_i, sda_i}),
    .dout  (line_s)
  );

  // quarter-bit enable
  // a slow line only lengthens a phase, the enable itself never stops
  always @(posedge mclk) begin
    if (reset) begin
      qcnt <= {`QDAC_QTR_W{1'b0}};
      tick <= 1'b0;
    end else begin
      tick <= (qcnt == QTR_LAST);
      qcnt <= (qcnt == QTR_LAST) ? {`QDAC_QTR_W{1'b0}} : qcnt + 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      state    <= S_IDLE;
      phase    <= 2'd0;
      bitn     <= 4'd0;
      idx      <= 3'd0;
      nw       <= 3'd0;
      is_rd    <= 1'b0;
      shreg    <= 8'hFF;
      hi_b     <= 8'h00;
      lo_b     <= 8'h00;
      ext_b    <= 8'h00;
      lsb      <= 1'b0;
      rback    <= 16'h0000;
      busy     <= 1'b0;
      nack     <= 1'b0;
      done     <= 1'b0;
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      case (state)
        S_IDLE: begin
          // a go while busy is dropped, software polls busy first
          if (go) begin
            hi_b  <= cmd[`QDAC_F_NIB_HI:`QDAC_F_CODE_HI-3];
            // sub-bits always sent as zero
            lo_b  <= {cmd[`QDAC_F_CODE_HI-4:`QDAC_F_CODE_LO], 2'b00};
            ext_b <= {cmd[`QDAC_F_SEL_LO], cmd[`QDAC_F_SEL_LO+1],
                      cmd[`QDAC_F_SEL_LO+2], cmd[`QDAC_F_SEL_HI],
                      cmd[`QDAC_F_SD_HI:`QDAC_F_SD_LO], 2'b00};
            lsb   <= cmd[`QDAC_F_LSB];
            if (cmd[`QDAC_F_NIB_HI:`QDAC_F_NIB_LO] == `QDAC_NIB_UPDATE) begin
              nw    <= 3'd2;
              is_rd <= 1'b0;
            end else if (cmd[`QDAC_F_NIB_HI:`QDAC_F_NIB_LO] ==
                         `QDAC_NIB_EXT) begin
              if (cmd[`QDAC_F_CODE_HI:`QDAC_F_CODE_HI-3] ==
                  `QDAC_CODE_TOP0) begin
                nw    <= 3'd4;
                is_rd <= 1'b0;
              end else begin
                nw    <= 3'd3;
                is_rd <= 1'b1;
              end
            end else begin
              nw    <= 3'd3;
              is_rd <= 1'b0;
            end
            idx   <= `QDAC_IDX_ADDR_W;
            busy  <= 1'b1;
            nack  <= 1'b0;
            done  <= 1'b0;
            phase <= 2'd0;
            state <= S_START;
          end
        end
        S_START: begin
          // from idle the clock is pulled low first, so a first start
          // and a repeated start share one path
          if (tick) begin
            case (phase)
              2'd0: scl_oe_n <= 1'b0;
              2'd1: sda_oe_n <= 1'b1;
              2'd2: scl_oe_n <= 1'b1;
              default: begin
                if (scl_s) begin
                  sda_oe_n <= 1'b0;
                  shreg    <= byte_at(idx, lsb, hi_b, lo_b, ext_b);
                  bitn     <= 4'd0;
                  state    <= S_BIT;
                end
              end
            endcase
            if (phase != 2'd3 || scl_s) begin
              phase <= phase + 2'd1;
            end
          end
        end
        S_BIT: begin
          if (tick) begin
            case (phase)
              2'd0: scl_oe_n <= 1'b0;
              2'd1: begin
                // data moves only with the clock held low
                if (bitn == `QDAC_ACK_BIT) begin
                  // ack the first read byte; the last read byte gets no ack
                  sda_oe_n <= !(rx_byte &&
                                idx != `QDAC_IDX_RD_LO);
                end else begin
                  sda_oe_n <= rx_byte ? 1'b1 : shreg[7];
                end
              end
              2'd2: scl_oe_n <= 1'b1;
              default: begin
                // a slave holding the clock low stretches this phase
                if (scl_s) begin
                  if (bitn != `QDAC_ACK_BIT) begin
                    shreg <= {shreg[6:0], sda_s};
                    bitn  <= bitn + 4'd1;
                  end else begin
                    // judged with the clock still high; the next state's
                    // first quarter gives the falling edge that ends the
                    // acknowledge, where the slave commits its registers
                    bitn <= 4'd0;
                    if (!rx_byte && sda_s) begin
                      nack  <= 1'b1;
                      state <= S_STOP;
                    end else if (idx == `QDAC_IDX_RD_HI) begin
                      rback[15:8] <= shreg;
                      idx         <= idx + 3'd1;
                      shreg       <= 8'hFF;
                    end else if (idx == `QDAC_IDX_RD_LO) begin
                      rback[7:0] <= shreg;
                      state      <= S_STOP;
                    end else if (idx == `QDAC_IDX_ADDR_R) begin
                      idx   <= `QDAC_IDX_RD_HI;
                      shreg <= 8'hFF;
                    end else if (idx + 3'd1 == nw) begin
                      if (is_rd) begin
                        idx   <= `QDAC_IDX_ADDR_R;
                        state <= S_START;
                      end else begin
                        state <= S_STOP;
                      end
                    end else begin
                      idx   <= idx + 3'd1;
                      shreg <= next_byte;
                    end
                  end
                end
              end
            endcase
            if (phase != 2'd3 || scl_s) begin
              phase <= phase + 2'd1;
            end
          end
        end
        S_STOP: begin
          // reached only after a full byte, so a clock always separates
          if (tick) begin
            case (phase)
              2'd0: scl_oe_n <= 1'b0;
              2'd1: sda_oe_n <= 1'b0;
              // clock released over a low data line sets up the stop
              2'd2: scl_oe_n <= 1'b1;
              default: begin
                if (scl_s) begin
                  sda_oe_n <= 1'b1;
                  busy     <= 1'b0;
                  done     <= 1'b1;
                  state    <= S_IDLE;
                end
              end
            endcase
            if (phase != 2'd3 || scl_s) begin
              phase <= phase + 2'd1;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== qdac_host_sva.sv ====
// Purpose: pin and register bus checks for the two-wire host
// Assumes: bench runs one quarter of a bit as four mclk cycles
// Notes:   open-drain lines, so the outputs must stay low and timing is watched on the enables
`timescale 1ns/1ps
`include "qdac_defines.vh"
module qdac_host_sva (
  // clock and reset
  input wire                mclk,
  input wire                reset,
  // register bus
  input wire [`QDAC_AW-1:0] awaddr,
  input wire                awvalid,
  input wire                awready,
  input wire [1:0]          bresp,
  // line outputs and enables
  input wire                scl_o,
  input wire                scl_oe_n,
  input wire                sda_o,
  input wire                sda_oe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence start_s;
    $fell(sda_oe_n) && scl_oe_n;
  endsequence
  sequence stop_s;
    $rose(sda_oe_n) && scl_oe_n;
  endsequence
  open_drain_a: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  sda_setup_a: assert property ($rose(scl_oe_n) |-> $stable(sda_oe_n))
    else $error("data moved at clock release");
  sda_hold_a: assert property ($fell(scl_oe_n) |-> $stable(sda_oe_n))
    else $error("data moved at clock fall");
  start_hold_a: assert property (start_s |=> scl_oe_n [*3])
    else $error("start hold too short");
  stop_free_a: assert property (stop_s |=> (scl_oe_n && sda_oe_n) [*3])
    else $error("bus not free after stop");
  start_clock_a: assert property (
    start_s |-> ##[1:12] ($fell(scl_oe_n) && !sda_oe_n))
    else $error("no clock pulse after start");
  scl_low_a: assert property ($fell(scl_oe_n) |=> !scl_oe_n [*3])
    else $error("clock low phase too short");
  bad_addr_a: assert property (awvalid && awready &&
    awaddr != `QDAC_REG_CMD && awaddr != `QDAC_REG_STAT
    |=> bresp == `QDAC_RESP_SLVERR)
    else $error("unmapped write not refused");
endmodule

bind qdac_host qdac_host_sva u_qdac_host_sva (
  .mclk(mclk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
  .awready(awready), .bresp(bresp), .scl_o(scl_o),
  .scl_oe_n(scl_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
);

// ==== qdac_slave_model.sv ====
// Purpose: behavioural quad converter slave on the two-wire bus
// Assumes: lines resolved by the bench with pull-ups
// Notes:   no clock stretching; data changes only while clock low
`timescale 1ns/1ps
module qdac_slave_model #(
  parameter [5:0] ADDR_HI = 6'h15 // arbitrary fixed address bits
) (
  // bus lines
  input  wire        scl,
  input  wire        sda,
  output reg         sda_pull,
  // strap pin and converter state
  input  wire        id_lsb,
  output reg  [39:0] outs,
  output reg  [7:0]  sds
);
  reg [39:0] ins;
  reg [7:0]  sh;
  reg [15:0] tx;
  reg [3:0]  nib;
  reg [9:0]  code;
  reg        act, rd, fin;
  integer    bc, byt, ph, rsel, i;
  initial begin
    {ins, outs, sda_pull, act, rd, fin} = 0;
    {bc, byt, ph, rsel} = 0;
    sds = 8'hFF;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1;
    rd = 0;
    {bc, byt, ph} = 0;
  end
  always @(posedge sda) if (scl === 1'b1) act = 0;
  always @(posedge scl) if (act) begin
    if (bc < 8) begin
      sh = {sh[6:0], sda};
      if (byt == 0 && bc < 7 && sda !== (bc == 6 ? id_lsb : ADDR_HI[5 - bc]))
        act = 0;
      bc = bc + 1;
    end else begin
      if (rd && byt > 0 && sda) act = 0; // master nack ends the read
      fin = act;
      bc = 0;
    end
  end
  // drives only on the falling clock, so data is stable while high
  always @(negedge scl) begin
    sda_pull = act && bc == 8 && !(rd && byt > 0);
    if (fin) begin
      fin = 0;
      if (byt == 0) begin
        rd = sh[0];
        tx = {4'hF, outs[rsel*10 +: 10], 2'b00};
      end else if (!rd) begin
        take(sh);
      end
      byt = byt + 1;
    end
    if (act && rd && byt > 0 && bc < 8) begin
      sda_pull = !tx[15];
      tx = tx << 1;
    end
  end
  task take(input [7:0] b);
    begin
      if (ph == 2) begin
        for (i = 0; i < 4; i = i + 1)
          if (b[7 - i]) sds[2*i +: 2] = b[3:2];
        ph = 0;
      end else if (ph == 0) begin
        {nib, code[9:6]} = b;
        ph = (nib == 4'hE) ? 0 : 1;
        if (nib == 4'hE) outs = ins;
      end else begin
        code[5:0] = b[7:2];
        ph = (nib == 4'hF && code[9:6] == 0) ? 2 : 0;
        if (nib[3:2] == 2'b10) outs = ins;
        if (nib < 4'hC) ins[nib[1:0]*10 +: 10] = code;
        if (nib == 4'hC || nib == 4'hD) ins = {4{code}};
        if (nib < 4'h4 || nib == 4'hC) outs = ins;
        if (nib == 4'hF && code[9:6] != 0)
          rsel = code[6] ? 0 : code[7] ? 1 : code[8] ? 2 : 3;
      end
    end
  endtask
endmodule

// ==== qdac_host_tb.sv ====
// Purpose: self-checking bench for the quad converter host controller
// Assumes: one link bit lasts 16 mclk cycles here
// Notes:   expected state is kept by a model in the bench
`timescale 1ns/1ps
`include "qdac_defines.vh"
module qdac_host_tb;
  localparam [5:0] HI = 6'h15; // arbitrary fixed address bits
  reg                mclk = 0, reset = 1, strap = 0;
  reg [`QDAC_AW-1:0] awaddr = 0, araddr = 0;
  reg [31:0]         wdata = 0, st;
  reg [3:0]          wstrb = 0;
  reg                awvalid = 0, wvalid = 0, bready = 0;
  reg                arvalid = 0, rready = 0;
  reg [39:0]         eo;
  reg [7:0]          es;
  reg [1:0]          r;
  wire               awready, wready, bvalid, arready, rvalid, pull;
  wire               scl_o, scl_oe_n, sda_o, sda_oe_n;
  wire [1:0]         bresp, rresp;
  wire [31:0]        rdata;
  wire [39:0]        outs;
  wire [7:0]         sds;
  wire               scl = scl_oe_n;
  wire               sda = sda_oe_n & !pull;
  integer            errors = 0, checked = 0, k, n;
  integer            e_in[4], e_out[4], e_sd[4];
  always #2 mclk = ~mclk;
  qdac_host #(.ADDR_HI(HI), .SCL_NS(64)) u_qdac_host (
    .mclk(mclk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  qdac_slave_model #(.ADDR_HI(HI)) u_qdac_slave_model (
    .scl(scl), .sda(sda), .sda_pull(pull), .id_lsb(strap),
    .outs(outs), .sds(sds));
  task end_of_test;
    begin
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input string name, input [39:0] seen, input [39:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("wrong value %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task guard(input f);
    if (f) begin
      errors = errors + 1;
      end_of_test;
    end
  endtask
  task axw(input [3:0] a, input [31:0] d, input [3:0] s);
    integer t;
    begin
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      {awvalid, wvalid, bready} <= 3'h7;
      t = 0;
      do begin
        @(posedge mclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        t = t + 1;
      end while (!bvalid && t < 200);
      r = bresp;
      bready <= 1'b0;
      @(posedge mclk);
      guard(t >= 200);
    end
  endtask
  task axr(input [3:0] a);
    integer t;
    begin
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      t = 0;
      do begin
        @(posedge mclk);
        if (arready) arvalid <= 1'b0;
        t = t + 1;
      end while (!rvalid && t < 200);
      st = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge mclk);
      guard(t >= 200);
    end
  endtask
  task do_cmd(input [3:0] nb, input [9:0] c, input [3:0] sel,
              input [1:0] pd, input bad);
    integer t;
    begin
      axw(`QDAC_REG_CMD, {1'b1, 6'h0, strap ^ bad, 2'b0, pd, sel, nb, c,
          2'b0}, 4'hF);
      t = 0;
      do begin
        axr(`QDAC_REG_STAT);
        t = t + 1;
      end while (st[`QDAC_F_DONE] !== 1'b1 && t < 1000);
      guard(t >= 1000);
      for (k = 0; k < 4 && !bad; k = k + 1) begin
        if (nb[3:2] == 2'b10 || nb == 4'hE)
          e_out[k] = e_in[k];
        if (nb < 12 && nb[1:0] == k || nb == 12 || nb == 13)
          e_in[k] = c;
        if (nb < 4 || nb == 12)
          e_out[k] = e_in[k];
        if (nb == 15 && c[9:6] == 0 && sel[k])
          e_sd[k] = pd;
      end
      for (k = 0; k < 4; k = k + 1) begin
        eo[k*10 +: 10] = e_out[k];
        es[k*2 +: 2] = e_sd[k];
      end
      chk("nack", st[`QDAC_F_NACK], bad);
      chk("outputs", outs, eo);
      chk("shutdown", sds, es);
    end
  endtask
  initial begin
    k = $urandom(8993);
    for (k = 0; k < 4; k = k + 1) begin
      e_in[k] = 0;
      e_out[k] = 0;
      e_sd[k] = 3;
    end
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    strap <= $urandom % 2;
    @(posedge mclk);
    axr(`QDAC_REG_STAT);
    chk("status reset", st, 0);
    axr(4'h8);
    chk("unmapped read", st, 0);
    chk("unmapped rresp", r, `QDAC_RESP_OKAY);
    axw(4'hC, 32'hFFFFFFFF, 4'hF);
    chk("unmapped resp", r, `QDAC_RESP_SLVERR);
    // go lane withheld: fields load, nothing starts
    axw(`QDAC_REG_CMD, 32'hFFFFFFFF, 4'h7);
    chk("command resp", r, `QDAC_RESP_OKAY);
    axr(`QDAC_REG_CMD);
    chk("command readback", st, 32'h003FFFFC);
    chk("outputs reset", outs, 0);
    for (n = 0; n < 5; n = n + 1)
      do_cmd(4'hF, $urandom % 64, n < 4 ? $urandom : 15, ~n, 0);
    for (n = 0; n < 15; n = n + 1)
      do_cmd(n, $urandom, 0, 0, 0);
    for (n = 0; n < 4; n = n + 1) begin
      do_cmd(4'hF, 10'h040 << n, 0, 0, 0);
      chk("readback", st[15:0], {4'hF, e_out[n][9:0], 2'b00});
    end
    do_cmd(4'hC, $urandom, 0, 0, 1);
    do_cmd($urandom % 4, $urandom, 0, 0, 0);
    end_of_test;
  end
endmodule
